// [design/kbd_link.sv]
// Keyboard-side serial link: framing, link clocking, host command handling
`default_nettype none

module kbd_link (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic [7:0] scan_data_i,
    input wire logic scan_valid_i,
    output logic scan_ready_o,
    input wire logic kbd_clk_i,
    output logic kbd_clk_o,
    output logic kbd_clk_oe_o,
    input wire logic kbd_data_i,
    output logic kbd_data_o,
    output logic kbd_data_oe_o,
    output logic led_scroll_o,
    output logic led_num_o,
    output logic led_caps_o,
    output logic [kbd_link_pkg::DATA_W-1:0] repeat_rate_o,
    output logic kbd_reset_o
);
    import kbd_link_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    byte_stream_if in_if ();
    byte_stream_if out_if ();

    // System domain
    logic [DATA_W-1:0] tx_data;
    logic tx_req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic rx_s1;
    logic rx_s2;
    logic rx_seen;
    logic busy;
    logic rx_new;
    logic reply_pend;
    logic [DATA_W-1:0] reply_byte;
    logic launch_reply;
    logic launch_scan;
    logic [DATA_W-1:0] last_scan;
    cmd_state_e cmd_state;
    logic cmd_reply;
    logic [DATA_W-1:0] next_reply;
    logic soft_rst;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic rst_hold;
    logic core_rst;

    // Link domain
    logic lrst_s1;
    logic link_rst;
    logic clk_s1;
    logic clk_s;
    logic data_s1;
    logic data_s;
    logic req_s1;
    logic req_s2;
    logic ack_tgl;
    logic rx_tgl;
    logic [DATA_W-1:0] rx_byte;
    link_state_e link_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] idle_cnt;
    logic [3:0] bit_cnt;
    logic low_phase;
    logic [FRAME_BITS-1:0] tx_shift;
    logic [FRAME_BITS-1:0] rx_shift;
    logic clk_oe;
    logic data_oe;
    logic tx_pend;
    logic bus_idle;
    logic half_done;
    logic frame_ok;

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    assign kbd_clk_o = 1'b0;
    assign kbd_data_o = 1'b0;
    assign kbd_clk_oe_o = clk_oe;
    assign kbd_data_oe_o = data_oe;

    // ------------------------------------------------------------------
    // Scan-code buffer
    // ------------------------------------------------------------------
    assign in_if.valid = scan_valid_i;
    assign in_if.data = scan_data_i;
    assign scan_ready_o = in_if.ready && !core_rst;
    // Replies go ahead of scan codes so a command is answered promptly
    assign out_if.ready = !busy && !reply_pend;
    assign launch_scan = out_if.valid && out_if.ready;
    assign launch_reply = !busy && reply_pend;

    byte_buffer u_buffer (
        .clock_i(clock_i),
        .sys_rst_i(core_rst),
        .flush_i(soft_rst),
        .push(in_if.snk),
        .pop(out_if.src)
    );

    // ------------------------------------------------------------------
    // System-side crossings
    // ------------------------------------------------------------------
    // A short reset pulse is stretched so the slower link clock is sure to catch it
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rst_cnt <= RST_CNT_W'(RST_HOLD_CYCLES);
            rst_hold <= 1'b1;
        end else begin
            if (rst_cnt != '0) begin
                rst_cnt <= rst_cnt - RST_CNT_W'(1);
            end
            rst_hold <= (rst_cnt != '0);
        end
    end

    assign core_rst = sys_rst_i || rst_hold;

    always_ff @(posedge clock_i) begin
        ack_s1 <= ack_tgl;
        ack_s2 <= ack_s1;
        rx_s1 <= rx_tgl;
        rx_s2 <= rx_s1;
        if (core_rst) begin
            rx_seen <= 1'b0;
        end else begin
            rx_seen <= rx_s2;
        end
    end

    assign busy = (tx_req_tgl != ack_s2);
    assign rx_new = (rx_s2 != rx_seen);

    // ------------------------------------------------------------------
    // Transmit launch
    // ------------------------------------------------------------------
    // tx_data holds still until the link toggles back, so the link may read it directly
    always_ff @(posedge clock_i) begin
        if (core_rst) begin
            tx_req_tgl <= 1'b0;
            tx_data <= '0;
        end else if (launch_reply) begin
            tx_data <= reply_byte;
            tx_req_tgl <= ~tx_req_tgl;
        end else if (launch_scan) begin
            tx_data <= out_if.data;
            tx_req_tgl <= ~tx_req_tgl;
        end
    end

    always_ff @(posedge clock_i) begin
        if (core_rst || soft_rst) begin
            last_scan <= LAST_SCAN_RST;
        end else if (launch_scan) begin
            last_scan <= out_if.data;
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    always_comb begin
        cmd_reply = 1'b0;
        next_reply = REPLY_ACK;
        soft_rst = 1'b0;
        if (rx_new) begin
            case (cmd_state)
                C_LED_ARG, C_RATE_ARG: begin
                    cmd_reply = 1'b1;
                end
                C_CMD: begin
                    case (rx_byte)
                        CMD_LED_SET, CMD_RATE_SET: begin
                            cmd_reply = 1'b1;
                        end
                        CMD_ECHO: begin
                            cmd_reply = 1'b1;
                            next_reply = CMD_ECHO;
                        end
                        CMD_RESEND: begin
                            cmd_reply = 1'b1;
                            next_reply = last_scan;
                        end
                        CMD_RESET: begin
                            cmd_reply = 1'b1;
                            soft_rst = 1'b1;
                        end
                        default: begin
                            cmd_reply = 1'b0;
                        end
                    endcase
                end
                default: begin
                    cmd_reply = 1'b0;
                end
            endcase
        end
    end

    // A new reply set in the launch cycle wins over the clear
    always_ff @(posedge clock_i) begin
        if (core_rst) begin
            reply_pend <= 1'b0;
            reply_byte <= REPLY_ACK;
        end else begin
            if (launch_reply) begin
                reply_pend <= 1'b0;
            end
            if (cmd_reply) begin
                reply_pend <= 1'b1;
                reply_byte <= next_reply;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (core_rst || soft_rst) begin
            cmd_state <= C_CMD;
            led_scroll_o <= LED_RST;
            led_num_o <= LED_RST;
            led_caps_o <= LED_RST;
            repeat_rate_o <= REPEAT_RATE_RST;
        end else if (rx_new) begin
            case (cmd_state)
                C_CMD: begin
                    if (rx_byte == CMD_LED_SET) begin
                        cmd_state <= C_LED_ARG;
                    end else if (rx_byte == CMD_RATE_SET) begin
                        cmd_state <= C_RATE_ARG;
                    end
                end
                C_LED_ARG: begin
                    led_scroll_o <= rx_byte[LED_SCROLL_BIT];
                    led_num_o <= rx_byte[LED_NUM_BIT];
                    led_caps_o <= rx_byte[LED_CAPS_BIT];
                    cmd_state <= C_CMD;
                end
                C_RATE_ARG: begin
                    repeat_rate_o <= rx_byte;
                    cmd_state <= C_CMD;
                end
                default: begin
                    cmd_state <= C_CMD;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (core_rst) begin
            kbd_reset_o <= 1'b0;
        end else begin
            kbd_reset_o <= soft_rst;
        end
    end

    // ------------------------------------------------------------------
    // Link-side synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        lrst_s1 <= rst_hold;
        link_rst <= lrst_s1;
        clk_s1 <= kbd_clk_i;
        clk_s <= clk_s1;
        data_s1 <= kbd_data_i;
        data_s <= data_s1;
        req_s1 <= tx_req_tgl;
        req_s2 <= req_s1;
    end

    assign tx_pend = (req_s2 != ack_tgl);
    assign bus_idle = (idle_cnt == TIMER_W'(IDLE_CYCLES));
    assign half_done = (timer == TIMER_W'(HALF_CYCLES - 1));
    assign frame_ok = !rx_shift[START_POS] && rx_shift[STOP_POS] && (^rx_shift[PARITY_POS:DATA_LSB_POS]);

    // Both lines must stay high a full idle time; a host hold-off restarts the count
    always_ff @(posedge link_clk_i) begin
        if (link_rst || !clk_s || !data_s) begin
            idle_cnt <= '0;
        end else if (!bus_idle) begin
            idle_cnt <= idle_cnt + TIMER_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Link engine
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            link_state <= L_IDLE;
            timer <= '0;
            bit_cnt <= 4'h0;
            low_phase <= 1'b0;
            clk_oe <= 1'b0;
            data_oe <= 1'b0;
            tx_shift <= '0;
            rx_shift <= '0;
            ack_tgl <= 1'b0;
            rx_tgl <= 1'b0;
            rx_byte <= '0;
        end else begin
            case (link_state)
                L_IDLE: begin
                    clk_oe <= 1'b0;
                    data_oe <= 1'b0;
                    timer <= '0;
                    bit_cnt <= 4'h0;
                    low_phase <= 1'b0;
                    if (clk_s && !data_s) begin
                        link_state <= L_RX;
                    end else if (tx_pend && bus_idle) begin
                        link_state <= L_TX;
                        tx_shift <= {1'b1, ~^tx_data, tx_data, 1'b0};
                        data_oe <= 1'b1;
                    end
                end
                L_TX, L_RX: begin
                    if (!half_done) begin
                        timer <= timer + TIMER_W'(1);
                    end else begin
                        timer <= '0;
                        if (!low_phase) begin
                            // Clock still low after release means the host is holding off
                            if (!clk_s) begin
                                link_state <= L_IDLE;
                                data_oe <= 1'b0;
                            end else begin
                                clk_oe <= 1'b1;
                                low_phase <= 1'b1;
                                if ((link_state == L_RX) && (bit_cnt < 4'(FRAME_BITS))) begin
                                    rx_shift <= {data_s, rx_shift[FRAME_BITS-1:1]};
                                end
                            end
                        end else begin
                            clk_oe <= 1'b0;
                            low_phase <= 1'b0;
                            if (link_state == L_TX) begin
                                if (bit_cnt == 4'(FRAME_BITS - 1)) begin
                                    link_state <= L_IDLE;
                                    data_oe <= 1'b0;
                                    ack_tgl <= ~ack_tgl;
                                end else begin
                                    bit_cnt <= bit_cnt + 4'h1;
                                    tx_shift <= {1'b0, tx_shift[FRAME_BITS-1:1]};
                                    // Data changes only with the clock high
                                    data_oe <= ~tx_shift[1];
                                end
                            end else if (bit_cnt == 4'(FRAME_BITS - 1)) begin
                                bit_cnt <= bit_cnt + 4'h1;
                                data_oe <= 1'b1;
                            end else if (bit_cnt == 4'(ACK_BIT_INDEX)) begin
                                link_state <= L_IDLE;
                                data_oe <= 1'b0;
                                if (frame_ok) begin
                                    rx_byte <= rx_shift[PARITY_POS-1:DATA_LSB_POS];
                                    rx_tgl <= ~rx_tgl;
                                end
                            end else begin
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                end
                default: begin
                    link_state <= L_IDLE;
                end
            endcase
        end
    end

endmodule : kbd_link

`default_nettype wire

// [design/kbd_link_pkg.sv]
// Shared constants and types for the keyboard-style serial link
`default_nettype none

package kbd_link_pkg;

    // ------------------------------------------------------------------
    // Word framing
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FRAME_BITS = 11;
    localparam int ACK_BIT_INDEX = 11;
    localparam int START_POS = 0;
    localparam int PARITY_POS = 9;
    localparam int STOP_POS = 10;
    localparam int DATA_LSB_POS = 1;

    // ------------------------------------------------------------------
    // Host command and reply codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_LED_SET = 8'hED;
    localparam logic [7:0] CMD_ECHO = 8'hEE;
    localparam logic [7:0] CMD_RATE_SET = 8'hF3;
    localparam logic [7:0] CMD_RESEND = 8'hFE;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] REPLY_ACK = 8'hFA;

    // ------------------------------------------------------------------
    // Indicator byte layout and reset values
    // ------------------------------------------------------------------
    localparam int LED_SCROLL_BIT = 0;
    localparam int LED_NUM_BIT = 1;
    localparam int LED_CAPS_BIT = 2;
    localparam logic LED_RST = 1'b0;
    localparam logic [7:0] REPEAT_RATE_RST = 8'h00;
    localparam logic [7:0] LAST_SCAN_RST = 8'h00;

    // ------------------------------------------------------------------
    // Link timing, counted on the link clock; the reset hold is counted on the system clock
    // ------------------------------------------------------------------
    localparam int LINK_CLK_PERIOD_NS = 125;
    localparam int BIT_HALF_NS = 20000;
    localparam int BUS_IDLE_NS = 50000;
    localparam int HALF_CYCLES = BIT_HALF_NS / LINK_CLK_PERIOD_NS;
    localparam int IDLE_CYCLES = (BUS_IDLE_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
    localparam int TIMER_W = 9;
    localparam int RST_HOLD_CYCLES = 24;
    localparam int RST_CNT_W = 5;

    // ------------------------------------------------------------------
    // Buffer and state types
    // ------------------------------------------------------------------
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        L_IDLE,
        L_TX,
        L_RX
    } link_state_e;

    typedef enum logic [1:0] {
        C_CMD,
        C_LED_ARG,
        C_RATE_ARG
    } cmd_state_e;

endpackage : kbd_link_pkg

`default_nettype wire

// [design/byte_stream_if.sv]
// Valid/ready byte stream carrier between the link top and its buffer
`default_nettype none

interface byte_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

`default_nettype wire

// [design/byte_buffer.sv]
// Two-entry valid/ready byte buffer with flush
`default_nettype none

module byte_buffer (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic flush_i,
    byte_stream_if.snk push,
    byte_stream_if.src pop
);
    import kbd_link_pkg::*;

    logic [DATA_W-1:0] mem [BUF_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic do_push;
    logic do_pop;

    assign push.ready = (count != 2'(BUF_DEPTH));
    assign pop.valid = (count != 2'h0);
    assign pop.data = mem[rd_ptr];
    assign do_push = push.valid && push.ready;
    assign do_pop = pop.valid && pop.ready;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_entry
        always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
                mem[e] <= '0;
            end else if (do_push && (wr_ptr == 1'(e))) begin
                mem[e] <= push.data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || flush_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (do_pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (do_push && !do_pop) begin
                count <= count + 2'h1;
            end else if (do_pop && !do_push) begin
                count <= count - 2'h1;
            end
        end
    end

endmodule : byte_buffer

`default_nettype wire

// [verif/kbd_link_sva.sv]
// Concurrent checks on the keyboard link top-level ports
`default_nettype none

module kbd_link_sva (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic [7:0] scan_data_i,
    input wire logic scan_valid_i,
    input wire logic scan_ready_o,
    input wire logic kbd_clk_i,
    input wire logic kbd_clk_o,
    input wire logic kbd_clk_oe_o,
    input wire logic kbd_data_i,
    input wire logic kbd_data_o,
    input wire logic kbd_data_oe_o,
    input wire logic led_scroll_o,
    input wire logic led_num_o,
    input wire logic led_caps_o,
    input wire logic [kbd_link_pkg::DATA_W-1:0] repeat_rate_o,
    input wire logic kbd_reset_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import kbd_link_pkg::*;

    // ------------------------------------------------------------------
    // Helper counters: settle on the system clock, low_len and idle_len on the link clock
    // ------------------------------------------------------------------
    logic [5:0] settle;
    logic link_quiet;
    logic [8:0] low_len;
    logic [8:0] idle_len;

    // The link side leaves reset well after the port does, so its checks wait longer
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) settle <= 6'h3F;
        else if (settle != 6'h00) settle <= settle - 6'h01;
    end

    assign link_quiet = sys_rst_i || (settle != 6'h00);

    always_ff @(posedge link_clk_i) begin
        if (link_quiet || !kbd_clk_oe_o) low_len <= '0;
        else low_len <= low_len + 9'h001;
    end

    // Saturates so a long idle bus never wraps back to a small count
    always_ff @(posedge link_clk_i) begin
        if (link_quiet || !(kbd_clk_i && kbd_data_i)) idle_len <= '0;
        else if (idle_len != 9'h1FF) idle_len <= idle_len + 9'h001;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_clk_pull_only: assert property (@(posedge link_clk_i) disable iff (link_quiet)
        kbd_clk_o == 1'b0) else $error("clock pin driven high");
    a_data_pull_only: assert property (@(posedge link_clk_i) disable iff (link_quiet)
        kbd_data_o == 1'b0) else $error("data pin driven high");
    a_start_on_idle: assert property (@(posedge link_clk_i) disable iff (link_quiet)
        $rose(kbd_data_oe_o) && idle_len > 9'h0B4 |-> idle_len >= 9'h18E)
        else $error("word started on a busy bus");
    a_no_start_held: assert property (@(posedge link_clk_i) disable iff (link_quiet)
        (!kbd_clk_i && !kbd_clk_oe_o) [*8] |=> !$rose(kbd_data_oe_o))
        else $error("word started while clock held low");
    a_low_phase_len: assert property (@(posedge link_clk_i) disable iff (link_quiet)
        $fell(kbd_clk_oe_o) |-> low_len == 9'h0A0) else $error("clock low phase length wrong");
    a_data_stable_low: assert property (@(posedge link_clk_i) disable iff (link_quiet)
        kbd_clk_oe_o && $past(kbd_clk_oe_o) |-> $stable(kbd_data_oe_o))
        else $error("data moved while clock low");
    a_reset_single: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        kbd_reset_o |=> !kbd_reset_o) else $error("reset pulse longer than one cycle");
    a_reset_clears: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        kbd_reset_o |-> ##[0:2] (!led_scroll_o && !led_num_o && !led_caps_o && repeat_rate_o == '0))
        else $error("reset command left state behind");

    c_word_start: cover property (@(posedge link_clk_i) $rose(kbd_data_oe_o) && idle_len > 9'h0B4);
    c_buffer_full: cover property (@(posedge clock_i) $fell(scan_ready_o));
    c_reset_cmd: cover property (@(posedge clock_i) kbd_reset_o);
endmodule : kbd_link_sva

bind kbd_link kbd_link_sva i_sva (.*);

`default_nettype wire

// [verif/kbd_host.sv]
// Host-side model of the serial link, acting as link master
`default_nettype none

module kbd_host (
    input wire logic clk_w,
    input wire logic data_w,
    output logic clk_oe,
    output logic data_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        clk_oe = 1'b0;
        data_oe = 1'b0;
    end

    // Device bits are taken on the falling clock edge
    task automatic recv(output logic [10:0] w);
        for (int i = 0; i < 11; i++) begin
            @(negedge clk_w);
            w[i] = data_w;
        end
    endtask : recv

    // Request: clock low over a bit time, data low, clock released
    task automatic send(input logic [7:0] b, output logic ack);
        logic [10:0] w;
        w = {1'b1, ~^b, b, 1'b0};
        clk_oe = 1'b1;
        #50000;
        data_oe = 1'b1;
        #5000;
        clk_oe = 1'b0;
        // Bits change only while the device holds the clock low
        for (int i = 1; i < 12; i++) begin
            @(negedge clk_w);
            data_oe = (i < 11) ? ~w[i] : 1'b0;
        end
        @(negedge clk_w);
        ack = data_w;
        @(posedge clk_w);
    endtask : send
endmodule : kbd_host

`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench for the keyboard link
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import kbd_link_pkg::*;

    logic clock_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] scan_data_i = 8'h00;
    logic scan_valid_i = 1'b0;
    logic scan_ready_o, kbd_clk_oe_o, kbd_data_oe_o, led_scroll_o, led_num_o, led_caps_o, kbd_reset_o;
    logic [DATA_W-1:0] repeat_rate_o;
    logic host_clk_oe, host_data_oe;
    wire logic clk_w = !(kbd_clk_oe_o || host_clk_oe);
    wire logic data_w = !(kbd_data_oe_o || host_data_oe);
    int failures = 0;
    int comparisons = 0;
    int resets = 0;
    logic [7:0] sent [4] = '{8'h1C, 8'h5A, 8'h33, 8'h81};
    int n;

    always #25 clock_i = ~clock_i;
    initial begin
        #17;
        forever #62.5 link_clk_i = ~link_clk_i;
    end
    always @(negedge clock_i) if (kbd_reset_o === 1'b1) resets++;

    kbd_link i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
        .scan_data_i(scan_data_i), .scan_valid_i(scan_valid_i), .scan_ready_o(scan_ready_o),
        .kbd_clk_i(clk_w), .kbd_clk_o(), .kbd_clk_oe_o(kbd_clk_oe_o), .kbd_data_i(data_w),
        .kbd_data_o(), .kbd_data_oe_o(kbd_data_oe_o), .led_scroll_o(led_scroll_o),
        .led_num_o(led_num_o), .led_caps_o(led_caps_o), .repeat_rate_o(repeat_rate_o),
        .kbd_reset_o(kbd_reset_o));
    kbd_host i_host (.clk_w(clk_w), .data_w(data_w), .clk_oe(host_clk_oe), .data_oe(host_data_oe));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [10:0] frame(input logic [7:0] b);
        return {1'b1, ~^b, b, 1'b0};
    endfunction : frame

    task automatic cmd(input logic [7:0] c, input logic [7:0] reply);
        logic ack;
        logic [10:0] w;
        i_host.send(c, ack);
        check("ack", 11'h000, {10'h000, ack});
        i_host.recv(w);
        check("reply", frame(reply), w);
    endtask : cmd

    task automatic test_done();
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Fill the buffer while the host inhibits, then drain it in order
    task automatic t_inhibit_stream();
        logic [10:0] w;
        host_clk_oe = 1'b1;
        for (n = 0; n < 4; n++) begin
            @(negedge clock_i);
            if (scan_ready_o !== 1'b1) break;
            scan_data_i = sent[n];
            scan_valid_i = 1'b1;
            @(negedge clock_i);
            scan_valid_i = 1'b0;
        end
        check("words taken", 11'h001, {10'h000, n >= 2 && n <= 3});
        #100000;
        check("data held off", 11'h000, {10'h000, kbd_data_oe_o});
        host_clk_oe = 1'b0;
        for (int i = 0; i < n; i++) begin
            i_host.recv(w);
            check("scan word", frame(sent[i]), w);
        end
    endtask : t_inhibit_stream

    task automatic t_led_rate();
        cmd(CMD_LED_SET, REPLY_ACK);
        cmd(8'hFD, REPLY_ACK);
        check("indicators", 11'h005, {8'h00, led_caps_o, led_num_o, led_scroll_o});
        cmd(CMD_RATE_SET, REPLY_ACK);
        cmd(8'h2B, REPLY_ACK);
        check("repeat rate", 11'h02B, {3'h0, repeat_rate_o});
    endtask : t_led_rate

    task automatic t_reset();
        cmd(CMD_RESET, REPLY_ACK);
        check("reset pulses", 11'h001, 11'(resets));
        check("cleared", 11'h000, {7'h00, led_caps_o, led_num_o, led_scroll_o, |repeat_rate_o});
    endtask : t_reset

    initial begin
        #12000000;
        failures++;
        test_done();
    end

    initial begin
        repeat (2) @(negedge clock_i);
        sys_rst_i = 1'b0;
        #2000;
        t_inhibit_stream();
        cmd(CMD_RESEND, sent[n-1]);
        cmd(CMD_ECHO, CMD_ECHO);
        t_led_rate();
        t_reset();
        test_done();
    end
endmodule : tb_top

`default_nettype wire
